// File: logic/dtc_pkg.sv
`default_nettype none
package dtc_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special function register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Clock select register.
  localparam int CS_T3H = 7;
  localparam int CS_T3L = 6;
  localparam int CS_T2H = 5;
  localparam int CS_T2L = 4;
  localparam int CS_T1SYS = 3;
  localparam int CS_T0SYS = 2;
  localparam int CS_DIV_LSB = 0;
  // Run and flag register.
  localparam int RF_OVF1 = 7;
  localparam int RF_RUN1 = 6;
  localparam int RF_OVF0 = 5;
  localparam int RF_RUN0 = 4;
  // Mode register, timer 1 in the upper nibble, timer 0 in the lower.
  localparam int MD_TIMER1_PIN_GATING = 7;
  localparam int MD_CNT1 = 6;
  localparam int MD_MODE1_LSB = 4;
  localparam int MD_TIMER0_PIN_GATING = 3;
  localparam int MD_CNT0 = 2;
  localparam int MD_MODE0_LSB = 0;

  // ----------------------------------------------------------------
  // Mode and divider encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] DIV_SEL_12 = 2'h0;
  localparam logic [1:0] DIV_SEL_4 = 2'h1;
  localparam logic [1:0] DIV_SEL_48 = 2'h2;
  localparam logic [1:0] DIV_SEL_EXT = 2'h3;

  // ----------------------------------------------------------------
  // Timing counts (terminal values of the dividers)
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV12_LAST = 6'h0B;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV48_LAST = 6'h2F;
  localparam logic [2:0] EXT_DIV8_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } dtc_cnt_t;

  typedef struct packed {
    logic [7:0] clk_sel;
    logic [7:0] run_flag;
    logic [7:0] mode;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [5:0] presc_cnt;
    logic [2:0] ext_cnt;
    logic [2:0] ext_sync;
    logic presc_tick;
    logic [2:0] pin0_sync;
    logic [2:0] pin1_sync;
    logic [1:0] timer0_pin_gating_sync;
    logic [1:0] timer1_pin_gating_sync;
    logic irq0;
    logic irq1;
    logic t1_ovf;
    logic [7:0] rdata;
  } dtc_state_t;

endpackage
`default_nettype wire

// File: logic/dtc_timer01.sv
// Behaviour
// - Prescaled tick is system clock divided by 12, 4 or 48 for codes 00,01,10.
// - Code 11 gives external oscillator divided by 8, resynchronised to system clock.
// - Timer 1 in timer mode counts system clocks when its select is 1, else prescaled.
// - Timer 0 in timer mode counts system clocks when its select is 1, else prescaled.
// - Timer 2 low and high clock selects come out of the clock select register.
// - Timer 3 low and high clock selects come out of the clock select register.
// - Each timer holds a 16-bit count read and written as two bytes.
// - 13-bit mode uses high byte and low bits 4..0; low bits 7..5 are don't care.
// - 13-bit wrap from 0x1FFF to 0x0000 sets the overflow flag.
// - Count select 1 increments once per falling edge on the count pin.
// - Timer counts only when run is 1 and gating is off or gate input active.
// - Setting run never clears the count; counting resumes from loaded value.
// - Timer 1 uses gate input 1 with its polarity and its own control bits.
// - 16-bit mode counts with all sixteen bits.
// - 8-bit reload: low byte wraps, sets flag, reloads from unchanged high byte.
// - Split mode low byte is a full 8-bit timer using timer 0 controls.
// - Split mode high byte counts only clocks and runs only with timer 1 run bit.
// - Split mode high byte overflow sets the timer 1 overflow flag.
// - In split mode timer 1 takes no pin edges and never sets its flag.
// - In split mode timer 1 still presents its overflow pulse to other blocks.
// - Timer 1 stops in mode 3; in split mode modes 0 to 2 make it run.
// - Interrupt request is flag set and its allow bit set.
// - Mode 00 13-bit, 01 16-bit, 10 reload, 11 split or stopped.
// - Flag set by overflow, cleared by software or on interrupt vectoring.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer01 (
  // Clock and reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // Register bus.
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  // External pins and oscillator.
  input wire logic I_EXT_OSC,
  input wire logic I_TIMER0_COUNT_PIN,
  input wire logic I_TIMER1_COUNT_PIN,
  input wire logic I_EXT_GATE_INPUT0,
  input wire logic I_EXT_GATE_INPUT1,
  // Interrupt controller side.
  input wire logic I_TIMER0_PIN_GATING_POLARITY,
  input wire logic I_TIMER1_PIN_GATING_POLARITY,
  input wire logic I_TIMER0_IRQ_ALLOW,
  input wire logic I_TIMER1_IRQ_ALLOW,
  input wire logic I_TIMER0_VECTOR,
  input wire logic I_TIMER1_VECTOR,
  output logic O_TIMER0_IRQ,
  output logic O_TIMER1_IRQ,
  // Other blocks.
  output logic O_TIMER1_OVF,
  output logic O_TIMER2_LOW_CLK_SELECT,
  output logic O_TIMER2_HIGH_CLK_SELECT,
  output logic O_TIMER3_LOW_CLK_SELECT,
  output logic O_TIMER3_HIGH_CLK_SELECT
);

  // ----------------------------------------------------------------
  // Counting step shared by both timers
  // ----------------------------------------------------------------
  // The split mode code steps the low byte like the reload mode does;
  // unlike the reload mode it never reloads, so the low byte wraps to zero.
  function automatic dtc_pkg::dtc_cnt_t step_count(input logic [1:0] mode,
                                                   input logic [7:0] low,
                                                   input logic [7:0] high);
    dtc_pkg::dtc_cnt_t res;
    logic [12:0] c13;
    logic [15:0] c16;
    res = '{low: low, high: high, ovf: 1'b0};
    c13 = {high, low[4:0]} + 13'h0001;
    c16 = {high, low} + 16'h0001;
    case (mode)
      dtc_pkg::MODE_13BIT: begin
        res.low = {low[7:5], c13[4:0]};
        res.high = c13[12:5];
        res.ovf = &{high, low[4:0]};
      end
      dtc_pkg::MODE_16BIT: begin
        res.low = c16[7:0];
        res.high = c16[15:8];
        res.ovf = &{high, low};
      end
      dtc_pkg::MODE_RELOAD: begin
        res.ovf = &low;
        res.low = res.ovf ? high : low + 8'h01;
      end
      default: begin
        res.ovf = &low;
        res.low = low + 8'h01;
      end
    endcase
    return res;
  endfunction

  dtc_pkg::dtc_state_t st_ff;
  dtc_pkg::dtc_state_t nxt_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Pin, gate and oscillator inputs pass synchronisers first, so the count pins see exactly
  // two flip-flops before any edge logic looks at them.
  always_comb begin
    logic [1:0] div_sel;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split;
    logic [5:0] presc_last;
    logic ext_edge;
    logic fall0;
    logic fall1;
    logic timer0_pin_gating_act;
    logic timer1_pin_gating_act;
    logic en0;
    logic en1;
    logic en0h;
    logic tick0;
    logic tick1;
    logic tick0h;
    logic set0;
    logic set1;
    logic ovf1_pulse;
    logic clr0;
    logic clr1;
    logic sw_rf;
    dtc_pkg::dtc_cnt_t r0;
    dtc_pkg::dtc_cnt_t r1;
    // Every local starts from a known value so no path can infer a latch.
    div_sel = 2'h0;
    mode0 = 2'h0;
    mode1 = 2'h0;
    split = 1'b0;
    presc_last = 6'h00;
    ext_edge = 1'b0;
    fall0 = 1'b0;
    fall1 = 1'b0;
    timer0_pin_gating_act = 1'b0;
    timer1_pin_gating_act = 1'b0;
    en0 = 1'b0;
    en1 = 1'b0;
    en0h = 1'b0;
    tick0 = 1'b0;
    tick1 = 1'b0;
    tick0h = 1'b0;
    set0 = 1'b0;
    set1 = 1'b0;
    ovf1_pulse = 1'b0;
    clr0 = 1'b0;
    clr1 = 1'b0;
    sw_rf = 1'b0;
    r0 = '0;
    r1 = '0;
    nxt_st = st_ff;
    div_sel = st_ff.clk_sel[dtc_pkg::CS_DIV_LSB +: 2];
    mode0 = st_ff.mode[dtc_pkg::MD_MODE0_LSB +: 2];
    mode1 = st_ff.mode[dtc_pkg::MD_MODE1_LSB +: 2];
    split = (mode0 == dtc_pkg::MODE_SPLIT);

    // Synchronisers: the first stage feeds only the second.
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], I_EXT_OSC};
    nxt_st.pin0_sync = {st_ff.pin0_sync[1:0], I_TIMER0_COUNT_PIN};
    nxt_st.pin1_sync = {st_ff.pin1_sync[1:0], I_TIMER1_COUNT_PIN};
    nxt_st.timer0_pin_gating_sync = {st_ff.timer0_pin_gating_sync[0], I_EXT_GATE_INPUT0};
    nxt_st.timer1_pin_gating_sync = {st_ff.timer1_pin_gating_sync[0], I_EXT_GATE_INPUT1};
    fall0 = st_ff.pin0_sync[2] & ~st_ff.pin0_sync[1];
    fall1 = st_ff.pin1_sync[2] & ~st_ff.pin1_sync[1];
    ext_edge = st_ff.ext_sync[1] & ~st_ff.ext_sync[2];

    // Free running prescaler; it never gates the clock, it only pulses.
    case (div_sel)
      dtc_pkg::DIV_SEL_4: presc_last = dtc_pkg::DIV4_LAST;
      dtc_pkg::DIV_SEL_48: presc_last = dtc_pkg::DIV48_LAST;
      default: presc_last = dtc_pkg::DIV12_LAST;
    endcase
    // Shrinking the divide ratio must not strand the counter past its end.
    if (st_ff.presc_cnt >= presc_last) begin
      nxt_st.presc_cnt = 6'h00;
    end else begin
      nxt_st.presc_cnt = st_ff.presc_cnt + 6'h01;
    end
    if (ext_edge) begin
      nxt_st.ext_cnt = st_ff.ext_cnt + 3'h1;
    end
    if (div_sel == dtc_pkg::DIV_SEL_EXT) begin
      nxt_st.presc_tick = ext_edge && (st_ff.ext_cnt == dtc_pkg::EXT_DIV8_LAST);
    end else begin
      nxt_st.presc_tick = (st_ff.presc_cnt >= presc_last);
    end

    // Gate inputs are active high when the polarity setting is 1.
    timer0_pin_gating_act = ~(st_ff.timer0_pin_gating_sync[1] ^ I_TIMER0_PIN_GATING_POLARITY);
    timer1_pin_gating_act = ~(st_ff.timer1_pin_gating_sync[1] ^ I_TIMER1_PIN_GATING_POLARITY);
    en0 = st_ff.run_flag[dtc_pkg::RF_RUN0] &
          (~st_ff.mode[dtc_pkg::MD_TIMER0_PIN_GATING] | timer0_pin_gating_act);
    // Timer 1 answers to its mode and gating, not its run bit, while timer 0 is split.
    en1 = (mode1 != dtc_pkg::MODE_SPLIT) &
          (split | st_ff.run_flag[dtc_pkg::RF_RUN1]) &
          (~st_ff.mode[dtc_pkg::MD_TIMER1_PIN_GATING] | timer1_pin_gating_act);
    en0h = split & st_ff.run_flag[dtc_pkg::RF_RUN1];

    // Count sources.
    if (st_ff.mode[dtc_pkg::MD_CNT0]) begin
      tick0 = fall0;
    end else begin
      tick0 = st_ff.clk_sel[dtc_pkg::CS_T0SYS] | st_ff.presc_tick;
    end
    if (st_ff.mode[dtc_pkg::MD_CNT1] & ~split) begin
      tick1 = fall1;
    end else begin
      tick1 = st_ff.clk_sel[dtc_pkg::CS_T1SYS] | st_ff.presc_tick;
    end
    tick0h = st_ff.clk_sel[dtc_pkg::CS_T0SYS] | st_ff.presc_tick;

    // Counters step only on enabled ticks; run set alone leaves them alone.
    r0 = step_count(mode0, st_ff.t0_low, st_ff.t0_high);
    r1 = step_count(mode1, st_ff.t1_low, st_ff.t1_high);
    set0 = 1'b0;
    set1 = 1'b0;
    ovf1_pulse = 1'b0;
    if (en0 && tick0) begin
      nxt_st.t0_low = r0.low;
      if (!split) begin
        nxt_st.t0_high = r0.high;
      end
      set0 = r0.ovf;
    end
    if (en0h && tick0h) begin
      nxt_st.t0_high = st_ff.t0_high + 8'h01;
      set1 = &st_ff.t0_high;
    end
    if (en1 && tick1) begin
      nxt_st.t1_low = r1.low;
      nxt_st.t1_high = r1.high;
      ovf1_pulse = r1.ovf;
      if (!split) begin
        set1 = set1 | r1.ovf;
      end
    end
    nxt_st.t1_ovf = ovf1_pulse;

    // Software writes to the count bytes win over the counting step.
    if (I_SFR_WR) begin
      case (I_SFR_ADDR)
        dtc_pkg::ADDR_CLOCK_SELECT: nxt_st.clk_sel = I_SFR_WDATA;
        dtc_pkg::ADDR_MODE: nxt_st.mode = I_SFR_WDATA;
        dtc_pkg::ADDR_TIMER0_LOW: nxt_st.t0_low = I_SFR_WDATA;
        dtc_pkg::ADDR_TIMER0_HIGH: nxt_st.t0_high = I_SFR_WDATA;
        dtc_pkg::ADDR_TIMER1_LOW: nxt_st.t1_low = I_SFR_WDATA;
        dtc_pkg::ADDR_TIMER1_HIGH: nxt_st.t1_high = I_SFR_WDATA;
        dtc_pkg::ADDR_RUN_FLAG: nxt_st.run_flag = I_SFR_WDATA;
        default: ;
      endcase
    end

    // Overflow flags: a hardware set in the same cycle beats any clear.
    sw_rf = I_SFR_WR && (I_SFR_ADDR == dtc_pkg::ADDR_RUN_FLAG);
    clr0 = I_TIMER0_VECTOR |
           (sw_rf & ~I_SFR_WDATA[dtc_pkg::RF_OVF0]);
    clr1 = I_TIMER1_VECTOR |
           (sw_rf & ~I_SFR_WDATA[dtc_pkg::RF_OVF1]);
    nxt_st.run_flag[dtc_pkg::RF_OVF0] = set0 |
      (sw_rf ? I_SFR_WDATA[dtc_pkg::RF_OVF0] : st_ff.run_flag[dtc_pkg::RF_OVF0]) & ~clr0;
    nxt_st.run_flag[dtc_pkg::RF_OVF1] = set1 |
      (sw_rf ? I_SFR_WDATA[dtc_pkg::RF_OVF1] : st_ff.run_flag[dtc_pkg::RF_OVF1]) & ~clr1;

    // Interrupt requests are registered from the next flag values, so they change with the flags.
    nxt_st.irq0 = nxt_st.run_flag[dtc_pkg::RF_OVF0] & I_TIMER0_IRQ_ALLOW;
    nxt_st.irq1 = nxt_st.run_flag[dtc_pkg::RF_OVF1] & I_TIMER1_IRQ_ALLOW;

    // Read data is registered: it shows the addressed byte one cycle later.
    case (I_SFR_ADDR)
      dtc_pkg::ADDR_CLOCK_SELECT: nxt_st.rdata = st_ff.clk_sel;
      dtc_pkg::ADDR_RUN_FLAG: nxt_st.rdata = st_ff.run_flag;
      dtc_pkg::ADDR_MODE: nxt_st.rdata = st_ff.mode;
      dtc_pkg::ADDR_TIMER0_LOW: nxt_st.rdata = st_ff.t0_low;
      dtc_pkg::ADDR_TIMER0_HIGH: nxt_st.rdata = st_ff.t0_high;
      dtc_pkg::ADDR_TIMER1_LOW: nxt_st.rdata = st_ff.t1_low;
      dtc_pkg::ADDR_TIMER1_HIGH: nxt_st.rdata = st_ff.t1_high;
      default: nxt_st.rdata = dtc_pkg::RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Every field resets to zero, which is also each register's reset value.
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register.
  assign O_SFR_RDATA = st_ff.rdata;
  assign O_TIMER0_IRQ = st_ff.irq0;
  assign O_TIMER1_IRQ = st_ff.irq1;
  assign O_TIMER1_OVF = st_ff.t1_ovf;
  assign O_TIMER2_LOW_CLK_SELECT = st_ff.clk_sel[dtc_pkg::CS_T2L];
  assign O_TIMER2_HIGH_CLK_SELECT = st_ff.clk_sel[dtc_pkg::CS_T2H];
  assign O_TIMER3_LOW_CLK_SELECT = st_ff.clk_sel[dtc_pkg::CS_T3L];
  assign O_TIMER3_HIGH_CLK_SELECT = st_ff.clk_sel[dtc_pkg::CS_T3H];

endmodule // dtc_timer01
`default_nettype wire

// File: logic/README_unused.sv
`default_nettype none
`default_nettype wire

// File: tb/dtc_timer01_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_timer01_chk (
  // Clock and reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // Register bus.
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] O_SFR_RDATA,
  // Interrupt side.
  input wire logic I_TIMER0_IRQ_ALLOW,
  input wire logic I_TIMER1_IRQ_ALLOW,
  input wire logic I_TIMER0_VECTOR,
  input wire logic O_TIMER0_IRQ,
  input wire logic O_TIMER1_IRQ,
  // Other blocks.
  input wire logic O_TIMER1_OVF,
  input wire logic O_TIMER2_LOW_CLK_SELECT,
  input wire logic O_TIMER2_HIGH_CLK_SELECT,
  input wire logic O_TIMER3_LOW_CLK_SELECT,
  input wire logic O_TIMER3_HIGH_CLK_SELECT
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  logic [1:0] mode1_ff;
  logic [1:0] nxt_mode1;
  logic wr_sel;
  // Shadow of the timer 1 mode field, rebuilt from bus writes alone.
  assign wr_sel = I_SFR_WR && (I_SFR_ADDR == dtc_pkg::ADDR_CLOCK_SELECT);
  assign nxt_mode1 = (I_SFR_WR && I_SFR_ADDR == dtc_pkg::ADDR_MODE) ? I_SFR_WDATA[5:4] : mode1_ff;
  // The shadow clears with the block so both agree after any reset.
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode1_ff <= 2'h0;
    end else begin
      mode1_ff <= nxt_mode1;
    end
  end
  clk_sel_out_a: assert property (wr_sel |=>
    ({O_TIMER3_HIGH_CLK_SELECT, O_TIMER3_LOW_CLK_SELECT, O_TIMER2_HIGH_CLK_SELECT,
    O_TIMER2_LOW_CLK_SELECT, 4'h0} == ($past(I_SFR_WDATA) & 8'hF0)))
    else $error("clock select pins differ from written byte");
  sel_readback_a: assert property (wr_sel ##1 (!I_SFR_WR &&
    I_SFR_ADDR == dtc_pkg::ADDR_CLOCK_SELECT) |=> O_SFR_RDATA == $past(I_SFR_WDATA, 2))
    else $error("clock select read back wrong");
  mode_readback_a: assert property ((I_SFR_WR && I_SFR_ADDR == dtc_pkg::ADDR_MODE)
    ##1 (!I_SFR_WR && I_SFR_ADDR == dtc_pkg::ADDR_MODE) |=>
    O_SFR_RDATA == $past(I_SFR_WDATA, 2)) else $error("mode register read back wrong");
  unmapped_zero_a: assert property ((I_SFR_ADDR < dtc_pkg::ADDR_RUN_FLAG ||
    I_SFR_ADDR > dtc_pkg::ADDR_CLOCK_SELECT) |=> O_SFR_RDATA == 8'h00)
    else $error("unmapped address read not zero");
  irq0_allow_a: assert property ($rose(O_TIMER0_IRQ) |-> $past(I_TIMER0_IRQ_ALLOW))
    else $error("timer 0 request without allow");
  irq1_allow_a: assert property (!I_TIMER1_IRQ_ALLOW |=> !O_TIMER1_IRQ)
    else $error("timer 1 request without allow");
  flag_sw_set_a: assert property ((I_SFR_WR && I_SFR_ADDR == dtc_pkg::ADDR_RUN_FLAG
    && I_SFR_WDATA[5]) ##1 (I_TIMER0_IRQ_ALLOW && !I_TIMER0_VECTOR && !I_SFR_WR)
    |=> O_TIMER0_IRQ) else $error("software set flag gave no request");
  t1_stop_a: assert property ((mode1_ff == 2'h3) [*3] |-> !O_TIMER1_OVF)
    else $error("timer 1 overflowed while stopped");
endmodule // dtc_timer01_chk
bind dtc_timer01 dtc_timer01_chk chk (.I_CLK_SYS, .I_RST_B, .I_SFR_ADDR, .I_SFR_WR,
  .I_SFR_WDATA, .O_SFR_RDATA, .I_TIMER0_IRQ_ALLOW, .I_TIMER1_IRQ_ALLOW, .I_TIMER0_VECTOR,
  .O_TIMER0_IRQ, .O_TIMER1_IRQ, .O_TIMER1_OVF, .O_TIMER2_LOW_CLK_SELECT,
  .O_TIMER2_HIGH_CLK_SELECT, .O_TIMER3_LOW_CLK_SELECT, .O_TIMER3_HIGH_CLK_SELECT);
`default_nettype wire

// File: tb/dtc_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_src (
  // Clock.
  input wire logic i_clk,
  // Request from the bench.
  input wire logic i_go,
  input wire logic [7:0] i_edges,
  // Count pin side.
  output logic o_pin,
  output logic o_busy
);
  // ----------
  // Event source
  // ----------
  // Idles high; each level lasts three clocks so the rate stays below a quarter clock.
  initial begin
    o_pin = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        repeat (i_edges) begin
          repeat (3) @(posedge i_clk);
          o_pin <= 1'b0;
          repeat (3) @(posedge i_clk);
          o_pin <= 1'b1;
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule // dtc_pin_src
`default_nettype wire

// File: tb/tb_dual_timer_counter_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_counter_prescaler;
  // ----------
  // Bench
  // ----------
  localparam int D = 2;
  logic clk, rst_b, wr, osc, g0, g1, pl0, pl1, al0, al1, v0, v1, go0, go1;
  logic p0, p1, b0, b1, irq0, irq1, ovf1, t2l, t2h, t3l, t3h;
  logic [7:0] addr, wd, rd, lf, n0, n1;
  int n_mismatch = 0;
  int n_tests = 0;
  int g, k, n_ovf = 0;
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
  // Free running clocks; the oscillator is unrelated in phase to the system clock.
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  initial begin osc = 1'b0; forever #65 osc = ~osc; end
  dtc_timer01 dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
    .I_SFR_WDATA(wd), .O_SFR_RDATA(rd), .I_EXT_OSC(osc), .I_TIMER0_COUNT_PIN(p0),
    .I_TIMER1_COUNT_PIN(p1), .I_EXT_GATE_INPUT0(g0), .I_EXT_GATE_INPUT1(g1),
    .I_TIMER0_PIN_GATING_POLARITY(pl0), .I_TIMER1_PIN_GATING_POLARITY(pl1), .I_TIMER0_IRQ_ALLOW(al0),
    .I_TIMER1_IRQ_ALLOW(al1), .I_TIMER0_VECTOR(v0), .I_TIMER1_VECTOR(v1),
    .O_TIMER0_IRQ(irq0), .O_TIMER1_IRQ(irq1), .O_TIMER1_OVF(ovf1),
    .O_TIMER2_LOW_CLK_SELECT(t2l), .O_TIMER2_HIGH_CLK_SELECT(t2h),
    .O_TIMER3_LOW_CLK_SELECT(t3l), .O_TIMER3_HIGH_CLK_SELECT(t3h));
  dtc_pin_src src0 (.i_clk(clk), .i_go(go0), .i_edges(n0), .o_pin(p0), .o_busy(b0));
  dtc_pin_src src1 (.i_clk(clk), .i_go(go1), .i_edges(n1), .o_pin(p1), .o_busy(b1));
  // Counts overflow pulses so event counts can be compared exactly.
  always @(posedge clk) if (ovf1 === 1'b1) n_ovf <= n_ovf + 1;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int div_of(input int c);
    return (c == 0) ? 12 : (c == 1) ? 4 : 48;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #D;
    addr = a; wd = d; wr = 1'b1;
    @(posedge clk); #D;
    wr = 1'b0;
  endtask
  // Read data lags the address by one edge, so two edges pass before sampling.
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); #D;
    addr = a;
    repeat (2) @(posedge clk);
    #D;
    `CHK("register", e, rd)
  endtask
  task automatic ovf_gap(output int n);
    int i;
    i = 0;
    do begin @(posedge clk); #D; i++; end while (ovf1 !== 1'b1 && i < 400);
    n = 0;
    do begin @(posedge clk); #D; n++; end while (ovf1 !== 1'b1 && n < 400);
  endtask
  task automatic irq_wait(input int w, output int n);
    n = 0;
    do begin @(posedge clk); #D; n++; end while ((w ? irq1 : irq0) !== 1'b1 && n < 300);
  endtask
  task automatic pulses(input logic [7:0] n);
    @(posedge clk); #D;
    n0 = n; n1 = n; go0 = 1'b1; go1 = 1'b1;
    @(posedge clk); #D;
    go0 = 1'b0; go1 = 1'b0;
    for (int i = 0; i < 400 && (b0 | b1) === 1'b1; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    #D;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin #2000000; n_mismatch++; end_of_test(); end
  initial begin
    logic [7:0] hi [3] = '{8'hFF, 8'hFF, 8'h80};
    logic [7:0] lo [3] = '{8'hFE, 8'hFD, 8'hFC};
    {wr, go0, go1, v0, v1, g0, g1, pl0, pl1, al0, al1} = '0;
    addr = 8'h00; wd = 8'h00; n0 = 8'h00; n1 = 8'h00; lf = 8'h60; rst_b = 1'b0;
    repeat (12) @(posedge clk);
    #D rst_b = 1'b1;
    for (int a = 8'h88; a <= 8'h8F; a++) chk_reg(8'(a), 8'h00);
    wr_reg(8'h8F, 8'hFF);
    chk_reg(8'h8F, 8'h00);
    repeat (4) begin
      lf = lfsr(lf);
      wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, lf);
      `CHK("select pins", lf[7:4], {t3h, t3l, t2h, t2l})
      chk_reg(dtc_pkg::ADDR_CLOCK_SELECT, lf);
    end
    al0 = 1'b1;
    wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h20);
    irq_wait(0, g);
    `CHK("soft flag", 1'b1, g <= 2)
    @(posedge clk); #D v0 = 1'b1;
    @(posedge clk); #D v0 = 1'b0;
    chk_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h00);
    // Each mode wraps after a known number of system clock steps from the load.
    wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, 8'h04);
    for (int m = 0; m < 3; m++) begin
      wr_reg(dtc_pkg::ADDR_MODE, 8'(m));
      wr_reg(dtc_pkg::ADDR_TIMER0_HIGH, hi[m]);
      wr_reg(dtc_pkg::ADDR_TIMER0_LOW, lo[m]);
      wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h10);
      irq_wait(0, g);
      `CHK("steps to wrap", m + 2, g)
      wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h00);
      chk_reg(dtc_pkg::ADDR_TIMER0_HIGH, (m == 2) ? 8'h80 : 8'h00);
    end
    wr_reg(dtc_pkg::ADDR_MODE, 8'h20);
    wr_reg(dtc_pkg::ADDR_TIMER1_HIGH, 8'hFF);
    wr_reg(dtc_pkg::ADDR_TIMER1_LOW, 8'hFF);
    wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h40);
    for (int c = 0; c < 3; c++) begin
      wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, 8'(c));
      ovf_gap(g);
      ovf_gap(g);
      `CHK("prescale gap", div_of(c), g)
    end
    wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, 8'h03);
    ovf_gap(g);
    ovf_gap(g);
    `CHK("oscillator gap", 1'b1, g == 20 || g == 21)
    wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, 8'h08);
    ovf_gap(g);
    `CHK("system gap", 1, g)
    // Gating: polarity, gate level and expected gap for each case.
    wr_reg(dtc_pkg::ADDR_MODE, 8'hA0);
    for (int j = 0; j < 4; j++) begin
      @(posedge clk); #D pl1 = (j < 2); g1 = (j == 1 || j == 2);
      repeat (5) @(posedge clk);
      ovf_gap(g);
      `CHK("gated gap", (pl1 == g1) ? 1 : 400, g)
    end
    wr_reg(dtc_pkg::ADDR_MODE, 8'h30);
    repeat (5) @(posedge clk);
    ovf_gap(g);
    `CHK("stopped gap", 400, g)
    wr_reg(dtc_pkg::ADDR_MODE, 8'h66);
    wr_reg(dtc_pkg::ADDR_TIMER0_HIGH, 8'hFD);
    wr_reg(dtc_pkg::ADDR_TIMER0_LOW, 8'hFD);
    wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h50);
    repeat (5) @(posedge clk);
    k = n_ovf;
    pulses(8'h02);
    `CHK("pin events", 2, n_ovf - k)
    chk_reg(dtc_pkg::ADDR_TIMER0_LOW, 8'hFF);
    pulses(8'h01);
    `CHK("pin wrap irq", 1'b1, irq0)
    chk_reg(dtc_pkg::ADDR_TIMER0_LOW, 8'hFD);
    // Split mode: the high byte of timer 0 runs on the timer 1 run bit.
    wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h00);
    k = n_ovf;
    wr_reg(dtc_pkg::ADDR_MODE, 8'h03);
    wr_reg(dtc_pkg::ADDR_CLOCK_SELECT, 8'h04);
    wr_reg(dtc_pkg::ADDR_TIMER0_HIGH, 8'hF0);
    al1 = 1'b1;
    wr_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h40);
    irq_wait(1, g);
    `CHK("split steps", 16, g)
    `CHK("split low idle", 1'b0, irq0)
    // Timer 1 starts at its last value, so it wraps once early and then stays far from a wrap.
    `CHK("split t1 pulse", 1, n_ovf - k)
    @(posedge clk); #D v1 = 1'b1;
    @(posedge clk); #D v1 = 1'b0;
    chk_reg(dtc_pkg::ADDR_RUN_FLAG, 8'h40);
    end_of_test();
  end
endmodule // tb_dual_timer_counter_prescaler
`default_nettype wire
